// >>> dv/gahac_check_sva.sv
// Concurrent checks on the holdoff and aux configuration ports
`timescale 1ns/1ps
module gahac_check
  import gahac_pkg::*;
(
  input wire logic       ref_clk,      // Clock
  input wire logic       rst_n,        // Reset
  input wire logic       host_wr,      // Write strobe
  input wire logic [2:0] host_offset,  // Port offset
  input wire logic [7:0] host_data,    // Write data
  input wire logic       byte_valid,   // Bus byte
  input wire logic       data_in_flag, // Bytes waiting
  input wire logic       rdy,          // Ready message
  input wire logic       holdoff,      // Ready held
  input wire logic       srq_state,    // Request state
  input wire logic       ist,          // Status
  input wire logic       int_req,      // Interrupt in
  input wire logic       int_pin,      // Interrupt pin
  input wire logic       src_start,    // Settle start
  input wire logic       src_first,    // First byte
  input wire logic       src_t1_done,  // Settled
  input wire logic       spas,         // Serial poll
  input wire logic       eoi_out,      // EOI value
  input wire logic       eoi_oe,       // EOI drive
  input wire logic       undef_cmd,    // Undefined cmd
  input wire logic       cpt_flag,     // Pass flag
  input wire logic       dac_hold      // DAC held
);
  logic [4:0] cfg_a;
  logic [4:0] cfg_b;
  logic       poll_flag;
  logic       aux;
  logic       fin;
  logic       vld;
  assign aux = host_wr && host_offset == AUX_MODE_OFFSET;
  assign fin = aux && host_data == {CODE_COMMAND, CMD_FINISH_HS};
  assign vld = aux && host_data == {CODE_COMMAND, CMD_VALID};
  // Shadow of write-only words, since the host cannot read them back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a     <= CFG_A_RESET;
      cfg_b     <= CFG_B_RESET;
      poll_flag <= 1'b0;
    end else if (aux) begin
      if (host_data[7:5] == CODE_CFG_A) cfg_a <= host_data[4:0];
      if (host_data[7:5] == CODE_CFG_B) cfg_b <= host_data[4:0];
      if (host_data == {CODE_COMMAND, CMD_SET_PPF}) poll_flag <= 1'b1;
      if (host_data == {CODE_COMMAND, CMD_CLR_PPF}) poll_flag <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_int_pol;
    int_pin == $past(int_req ^ cfg_b[INV_POS]);
  endproperty
  a_int_pol: assert property (p_int_pol) else $error("int pin level");
  property p_ist_srq;
    $past(cfg_b[ISS_POS]) |-> ist == $past(srq_state);
  endproperty
  a_ist_srq: assert property (p_ist_srq) else $error("ist not srq");
  property p_ist_flag;
    !$past(cfg_b[ISS_POS]) |-> ist == $past(poll_flag);
  endproperty
  a_ist_flag: assert property (p_ist_flag) else $error("ist not flag");
  property p_eoi;
    {eoi_oe, eoi_out} == $past({spas, spas & cfg_b[SERIAL_POLL_END_BIT_POS]});
  endproperty
  a_eoi: assert property (p_eoi) else $error("eoi wrong");
  property p_cpt_set;
    undef_cmd && cfg_b[CPT_EN_POS] |=> cpt_flag && dac_hold;
  endproperty
  a_cpt_set: assert property (p_cpt_set) else $error("cpt not set");
  property p_cpt_keep;
    cpt_flag && !vld |=> cpt_flag;
  endproperty
  a_cpt_keep: assert property (p_cpt_keep) else $error("cpt lost");
  property p_hold_set;
    byte_valid && cfg_a[1:0] == GAHAC_HOLD_ALL |=> holdoff;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("no holdoff");
  property p_hold_keep;
    holdoff && !fin |=> holdoff;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold lost");
  property p_hold_rdy;
    holdoff [*2] |-> !rdy;
  endproperty
  a_hold_rdy: assert property (p_hold_rdy) else $error("rdy in hold");
  property p_t1_slow;
    src_start && !(cfg_b[TRI_POS] && !src_first) |-> ##201 src_t1_done;
  endproperty
  a_t1_slow: assert property (p_t1_slow) else $error("slow t1");
  property p_t1_fast;
    src_start && cfg_b[TRI_POS] && !src_first |-> ##51 src_t1_done;
  endproperty
  a_t1_fast: assert property (p_t1_fast) else $error("fast t1");
  property p_cont_di;
    byte_valid && cfg_a[1:0] == GAHAC_CONTINUOUS && !data_in_flag
      |=> !data_in_flag;
  endproperty
  a_cont_di: assert property (p_cont_di) else $error("di set");
  // Main scenarios reached
  c_hold: cover property (byte_valid && cfg_a[1:0] == GAHAC_HOLD_ALL);
  c_cpt: cover property (cpt_flag);
  c_t1: cover property (src_t1_done);
endmodule : gahac_check
bind gahac_holdoff_ctrl gahac_check gahac_check_inst (.ref_clk, .rst_n,
  .host_wr, .host_offset, .host_data, .byte_valid, .data_in_flag, .rdy,
  .holdoff, .srq_state, .ist, .int_req, .int_pin, .src_start, .src_first,
  .src_t1_done, .spas, .eoi_out, .eoi_oe, .undef_cmd, .cpt_flag, .dac_hold);

// >>> dv/gahac_holdoff_ctrl_test.sv
// Self-checking bench for the holdoff and aux configuration block
`timescale 1ns/1ps
module gahac_holdoff_ctrl_test;
  import gahac_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, host_wr = 1'b0, dir_rd = 1'b0;
  logic [2:0] host_offset = 3'h0;
  logic [7:0] host_data = 8'h00, go_data = 8'h00, dir_data, byte_data;
  logic srq_state = 1'b0, int_req = 1'b0, src_start = 1'b0;
  logic src_first = 1'b0, spas = 1'b0, undef_cmd = 1'b0;
  logic go = 1'b0, go_end = 1'b0, data_in_flag, acceptor_not_ready_state, byte_valid;
  logic byte_end, rdy, holdoff, ist, int_pin, src_t1_done, eoi_out;
  logic eoi_oe, cpt_flag, dac_hold;
  int   n_errors = 0;
  int   tests_run = 0;
  gahac_holdoff_ctrl gahac_holdoff_ctrl_inst (.ref_clk, .rst_n, .host_wr,
    .host_offset, .host_data, .dir_rd, .dir_data, .data_in_flag, .acceptor_not_ready_state,
    .byte_valid, .byte_data, .byte_end, .rdy, .holdoff, .srq_state, .ist,
    .int_req, .int_pin, .src_start, .src_first, .src_t1_done, .spas,
    .eoi_out, .eoi_oe, .undef_cmd, .cpt_flag, .dac_hold);
  gahac_talker gahac_talker_inst (.ref_clk, .rst_n, .rdy, .go, .go_data,
    .go_end, .acceptor_not_ready_state, .byte_valid, .byte_data, .byte_end);
  // Free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic note(input string s);
    $display("test %s done, %0d errors", s, n_errors);
  endtask : note
  // One-cycle write, then room for the config to reach the outputs
  task automatic wr(input logic [2:0] off, input logic [7:0] d);
    host_wr = 1'b1;
    host_offset = off;
    host_data = d;
    tick(1);
    host_wr = 1'b0;
    tick(2);
  endtask : wr
  task automatic cmd(input logic [4:0] c);
    wr(AUX_MODE_OFFSET, {CODE_COMMAND, c});
  endtask : cmd
  task automatic send(input logic [7:0] d, input logic e);
    int n;
    n = 0;
    go = 1'b1;
    go_data = d;
    go_end = e;
    tick(1);
    go = 1'b0;
    while (byte_valid !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(byte_valid, 1'b1);
    tick(3);
  endtask : send
  task automatic rd(input logic [7:0] exp);
    dir_rd = 1'b1;
    tick(1);
    dir_rd = 1'b0;
    tick(2);
    check(dir_data, exp);
  endtask : rd
  task automatic t1(input logic f, input logic [7:0] exp);
    int n;
    n = 0;
    src_start = 1'b1;
    src_first = f;
    tick(1);
    src_start = 1'b0;
    while (src_t1_done !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(8'(n), exp);
    tick(1);
  endtask : t1
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // Watchdog sized well above the whole sequence
  initial begin
    #300000;
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    tick(5);
    rst_n = 1'b1;
    tick(1);
    check({int_pin, ist, eoi_oe, cpt_flag, holdoff}, 8'h00);
    wr(AUX_MODE_OFFSET, 8'ha8);
    check(int_pin, 1'b1);
    int_req = 1'b1;
    tick(2);
    check(int_pin, 1'b0);
    wr(AUX_MODE_OFFSET, 8'he0);
    check(int_pin, 1'b0);
    wr(3'h6, 8'ha0);
    check(int_pin, 1'b0);
    wr(AUX_MODE_OFFSET, 8'ha0);
    check(int_pin, 1'b1);
    int_req = 1'b0;
    note("polarity");
    srq_state = 1'b1;
    wr(AUX_MODE_OFFSET, 8'hb0);
    check(ist, 1'b1);
    srq_state = 1'b0;
    tick(2);
    check(ist, 1'b0);
    wr(AUX_MODE_OFFSET, 8'ha0);
    cmd(CMD_SET_PPF);
    check(ist, 1'b1);
    srq_state = 1'b1;
    cmd(CMD_CLR_PPF);
    check(ist, 1'b0);
    note("status");
    spas = 1'b1;
    wr(AUX_MODE_OFFSET, 8'ha2);
    check({eoi_oe, eoi_out}, 2'b11);
    wr(AUX_MODE_OFFSET, 8'ha0);
    check({eoi_oe, eoi_out}, 2'b10);
    spas = 1'b0;
    wr(AUX_MODE_OFFSET, 8'ha1);
    undef_cmd = 1'b1;
    tick(1);
    undef_cmd = 1'b0;
    tick(1);
    check({cpt_flag, dac_hold}, 2'b11);
    cmd(CMD_VALID);
    check({cpt_flag, dac_hold}, 2'b00);
    note("eoi and pass-through");
    wr(AUX_MODE_OFFSET, 8'ha0);
    t1(1'b0, 8'd200);
    wr(AUX_MODE_OFFSET, 8'ha4);
    t1(1'b0, 8'd50);
    t1(1'b1, 8'd200);
    note("settling");
    wr(AUX_MODE_OFFSET, 8'h80);
    for (int i = 0; i < FIFO_DEPTH; i++) send(8'h30 + 8'(i), 1'b0);
    check({data_in_flag, rdy}, 2'b10);
    for (int i = 0; i < FIFO_DEPTH; i++) rd(8'h30 + 8'(i));
    check({data_in_flag, rdy}, 2'b01);
    note("normal");
    wr(AUX_MODE_OFFSET, 8'h81);
    send(8'h55, 1'b0);
    check({holdoff, rdy}, 2'b10);
    rd(8'h55);
    check(rdy, 1'b0);
    cmd(CMD_FINISH_HS);
    check({holdoff, rdy}, 2'b01);
    note("hold all");
    wr(AUX_MODE_OFFSET, 8'h82);
    send(8'h11, 1'b0);
    check(holdoff, 1'b0);
    send(8'h12, 1'b1);
    check(holdoff, 1'b1);
    rd(8'h11);
    rd(8'h12);
    cmd(CMD_FINISH_HS);
    check(holdoff, 1'b0);
    wr(EOS_OFFSET, 8'h0a);
    wr(AUX_MODE_OFFSET, 8'h86);
    send(8'h8a, 1'b0);
    check(holdoff, 1'b1);
    rd(8'h8a);
    cmd(CMD_FINISH_HS);
    // Binary mode: all eight bits must match the end character
    wr(AUX_MODE_OFFSET, 8'h96);
    send(8'h8a, 1'b0);
    check(holdoff, 1'b0);
    send(8'h0a, 1'b0);
    check(holdoff, 1'b1);
    rd(8'h8a);
    rd(8'h0a);
    cmd(CMD_FINISH_HS);
    note("hold end");
    wr(AUX_MODE_OFFSET, 8'h83);
    send(8'h21, 1'b0);
    check({data_in_flag, holdoff, rdy}, 3'b001);
    send(8'h22, 1'b1);
    check({data_in_flag, holdoff, rdy}, 3'b010);
    cmd(CMD_FINISH_HS);
    check(rdy, 1'b1);
    note("continuous");
    results();
  end
endmodule : gahac_holdoff_ctrl_test

// >>> dv/gahac_talker.sv
// Bus talker model offering one byte at a time to the acceptor
`timescale 1ns/1ps
module gahac_talker (
  input  wire logic       ref_clk,    // Clock
  input  wire logic       rst_n,      // Reset
  input  wire logic       rdy,        // Acceptor ready
  input  wire logic       go,         // Offer a byte
  input  wire logic [7:0] go_data,    // Byte to offer
  input  wire logic       go_end,     // END with it
  output logic            acceptor_not_ready_state,       // Acceptor not ready
  output logic            byte_valid, // Byte taken
  output logic [7:0]      byte_data,  // Bus data
  output logic            byte_end    // END line
);
  logic       pend;
  logic [7:0] hold_d;
  logic       hold_e;
  // Released lines show the inverse, never a stale copy
  assign byte_data = byte_valid ? hold_d : ~hold_d;
  assign byte_end  = byte_valid & hold_e;
  assign acceptor_not_ready_state      = rst_n & !byte_valid;
  // Byte goes only once ready is seen, however long that takes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend       <= 1'b0;
      byte_valid <= 1'b0;
      hold_d     <= 8'h00;
      hold_e     <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      if (go) begin
        pend   <= 1'b1;
        hold_d <= go_data;
        hold_e <= go_end;
      end else if (pend && rdy) begin
        byte_valid <= 1'b1;
        pend       <= 1'b0;
      end
    end
  end
endmodule : gahac_talker

// >>> logic/gahac_fifo.sv
// Received byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module gahac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic     ref_clk,  // System clock
  input  wire logic     rst_n,    // Asynchronous reset, active low
  gahac_stream_if.buffer stream   // Fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } gahac_fifo_state_type;

  gahac_fifo_state_type state;
  gahac_fifo_state_type next_state;
  logic                 push;
  logic                 pop;

  // Honest full and empty straight from the count
  assign stream.in_ready  = (state.count != (AW+1)'(DEPTH));
  assign stream.out_valid = (state.count != '0);
  assign stream.out_data  = state.mem[state.rd_ptr];
  assign push = stream.in_valid & stream.in_ready;
  assign pop  = stream.out_valid & stream.out_ready;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and storage update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr_ptr] = stream.in_data;
      next_state.wr_ptr = state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : gahac_fifo

// >>> logic/gahac_holdoff_ctrl.sv
// Acceptor holdoff control and auxiliary configuration decode
// Operation
// - The two holdoff bits pick normal, hold-all, hold-at-end or continuous.
// - Normal mode issues ready in not-ready state while the buffer has room.
// - Hold-all mode keeps ready false after each byte until finish handshake.
// - In hold-all mode ready needs both the finish command and an empty buffer, in either order.
// - Hold-at-end mode holds only on END, or on EOS when end-on-EOS is set.
// - Continuous mode issues ready freely until end of block, then holds.
// - Continuous mode never raises the data-in flag for a received byte.
// - With status select set, individual status follows service request.
// - With status select clear, status is the poll flag set by aux commands.
// - The polarity bit makes the interrupt pin high active at 0, low at 1.
// - The timing bit picks 500 ns settling after the first byte, else 2 us.
// - In serial poll active state EOI follows the serial-poll end bit.
// - With pass-through on, an undefined command sets a flag and holds DAC.
`timescale 1ns/1ps
module gahac_holdoff_ctrl (
  input  wire logic                 ref_clk,     // System clock, 100 MHz
  input  wire logic                 rst_n,       // Async reset, active low
  input  wire logic                 host_wr,     // Host write strobe
  input  wire logic [2:0]           host_offset, // Host port offset
  input  wire logic [7:0]           host_data,   // Host write data
  input  wire logic                 dir_rd,      // Data-in register read
  output logic [7:0]                dir_data,    // Byte taken by last read
  output logic                      data_in_flag, // Bytes waiting
  input  wire logic                 acceptor_not_ready_state,        // Acceptor not ready state
  input  wire logic                 byte_valid,  // Byte accepted from bus
  input  wire logic [7:0]           byte_data,   // Accepted byte
  input  wire logic                 byte_end,    // END came with the byte
  output logic                      rdy,         // Local ready message
  output logic                      holdoff,     // Ready held off
  input  wire logic                 srq_state,   // Service request state
  output logic                      ist,         // Individual status
  input  wire logic                 int_req,     // Internal interrupt level
  output logic                      int_pin,     // Interrupt pin level
  input  wire logic                 src_start,   // Source byte placed
  input  wire logic                 src_first,   // Placed byte is the first
  output logic                      src_t1_done, // Settling time elapsed
  input  wire logic                 spas,        // Serial poll active state
  output logic                      eoi_out,     // EOI line value
  output logic                      eoi_oe,      // EOI driven
  input  wire logic                 undef_cmd,   // Undefined command seen
  output logic                      cpt_flag,    // Pass-through status
  output logic                      dac_hold     // Data accepted held
);
  import gahac_pkg::*;

  typedef struct packed {
    logic [4:0] cfg_a;
    logic [4:0] cfg_b;
    logic [7:0] eos;
    logic       hold;
    logic       pp_flag;
    logic [3:0] fill;
    logic [7:0] t1_count;
    logic       t1_run;
    logic       t1_done;
    logic [7:0] dir_data;
    logic       data_in;
    logic       rdy;
    logic       ist;
    logic       int_pin;
    logic       eoi_out;
    logic       eoi_oe;
    logic       cpt;
    logic       dac_hold;
  } gahac_ctrl_state_type;

  gahac_ctrl_state_type state;
  gahac_ctrl_state_type next_state;
  gahac_mode_type       mode;
  logic [2:0]           aux_control_code;
  logic [4:0]           aux_command_bits;
  logic                 aux_wr;
  logic                 cmd_wr;
  logic                 finish_cmd;
  logic                 eos_hit;
  logic                 block_end;
  logic                 end_on_eos_enable;

  gahac_stream_if #(.WIDTH(DATA_WIDTH)) stream ();

  gahac_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .stream  (stream)
  );

  ////////////////////////////////////////////////////////////////////////
  // Auxiliary mode port decode
  assign aux_control_code = host_data[7:5];
  assign aux_command_bits = host_data[4:0];
  assign aux_wr = host_wr & (host_offset == AUX_MODE_OFFSET);
  assign cmd_wr = aux_wr & (aux_control_code == CODE_COMMAND);
  assign finish_cmd = cmd_wr & (aux_command_bits == CMD_FINISH_HS);

  // Mode from end bit (high) and all bit (low)
  assign mode = gahac_mode_type'({state.cfg_a[HOLDOFF_END_POS],
                                  state.cfg_a[HOLDOFF_ALL_POS]});
  assign end_on_eos_enable = state.cfg_a[END_ON_EOS_ENABLE_POS];

  // End of block; seven-bit compare unless binary mode
  assign eos_hit = state.cfg_a[BIN_POS] ? (byte_data == state.eos) :
                   (byte_data[6:0] == state.eos[6:0]);
  assign block_end = byte_end | (end_on_eos_enable & eos_hit);

  // Continuous mode only watches, so nothing enters the buffer
  assign stream.in_valid  = byte_valid & (mode != GAHAC_CONTINUOUS);
  assign stream.in_data   = byte_data;
  assign stream.out_ready = dir_rd;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    // Configuration words and end-of-string character
    if (aux_wr && aux_control_code == CODE_CFG_A) begin
      next_state.cfg_a = aux_command_bits;
    end
    if (aux_wr && aux_control_code == CODE_CFG_B) begin
      next_state.cfg_b = aux_command_bits;
    end
    if (host_wr && host_offset == EOS_OFFSET) begin
      next_state.eos = host_data;
    end

    // Holdoff: a new byte that calls for it wins over finish
    if (finish_cmd) begin
      next_state.hold = 1'b0;
    end
    if (byte_valid) begin
      case (mode)
        GAHAC_NORMAL: begin
          next_state.hold = state.hold;
        end
        GAHAC_HOLD_ALL: begin
          next_state.hold = 1'b1;
        end
        GAHAC_HOLD_END: begin
          if (block_end) begin
            next_state.hold = 1'b1;
          end
        end
        GAHAC_CONTINUOUS: begin
          if (block_end) begin
            next_state.hold = 1'b1;
          end
        end
        default: begin
          next_state.hold = state.hold;
        end
      endcase
    end

    // Ready in not-ready state; normal and end modes need buffer room,
    // which a data-in read frees; reads alone never lift a holdoff
    case (mode)
      GAHAC_HOLD_ALL: begin
        next_state.rdy = acceptor_not_ready_state & ~next_state.hold & ~stream.out_valid;
      end
      GAHAC_CONTINUOUS: begin
        next_state.rdy = acceptor_not_ready_state & ~next_state.hold;
      end
      default: begin
        next_state.rdy = acceptor_not_ready_state & ~next_state.hold & stream.in_ready;
      end
    endcase

    // Data-in register captures the head on each read
    if (dir_rd && stream.out_valid) begin
      next_state.dir_data = stream.out_data;
    end
    // Own fill count, so the flag stays up while bytes remain after a read
    next_state.fill = state.fill + 4'(stream.in_valid & stream.in_ready)
                      - 4'(dir_rd & stream.out_valid);
    next_state.data_in = (next_state.fill != 4'h0);

    // Parallel poll flag and individual status
    if (cmd_wr && aux_command_bits == CMD_CLR_PPF) begin
      next_state.pp_flag = 1'b0;
    end
    if (cmd_wr && aux_command_bits == CMD_SET_PPF) begin
      next_state.pp_flag = 1'b1;
    end
    next_state.ist = state.cfg_b[ISS_POS] ? srq_state :
                     state.pp_flag;

    // Interrupt pin polarity
    next_state.int_pin = int_req ^ state.cfg_b[INV_POS];

    // Source settling timer; the first byte always waits the long time
    next_state.t1_done = 1'b0;
    if (src_start) begin
      next_state.t1_run = 1'b1;
      next_state.t1_count = (state.cfg_b[TRI_POS] && !src_first) ?
                            T1_FAST_CYCLES : T1_SLOW_CYCLES;
    end else if (state.t1_run) begin
      if (state.t1_count == 8'h01) begin
        next_state.t1_run = 1'b0;
        next_state.t1_done = 1'b1;
      end else begin
        next_state.t1_count = state.t1_count - 8'h01;
      end
    end

    // EOI while serial polled
    next_state.eoi_oe  = spas;
    next_state.eoi_out = spas & state.cfg_b[SERIAL_POLL_END_BIT_POS];

    // Command pass-through; a new command wins over valid
    if (cmd_wr && aux_command_bits == CMD_VALID) begin
      next_state.dac_hold = 1'b0;
      next_state.cpt = 1'b0;
    end
    if (undef_cmd && state.cfg_b[CPT_EN_POS]) begin
      next_state.cpt = 1'b1;
      next_state.dac_hold = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.cfg_a <= CFG_A_RESET;
      state.cfg_b <= CFG_B_RESET; // Polarity bit clear
      state.eos <= EOS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign dir_data     = state.dir_data;
  assign data_in_flag = state.data_in;
  assign rdy          = state.rdy;
  assign holdoff      = state.hold;
  assign ist          = state.ist;
  assign int_pin      = state.int_pin;
  assign src_t1_done  = state.t1_done;
  assign eoi_out      = state.eoi_out;
  assign eoi_oe       = state.eoi_oe;
  assign cpt_flag     = state.cpt;
  assign dac_hold     = state.dac_hold;
endmodule : gahac_holdoff_ctrl

// >>> pkg/gahac_pkg.sv
// Constants and types for the acceptor holdoff and aux configuration block
package gahac_pkg;
  // Port offsets seen by the host
  localparam logic [2:0] AUX_MODE_OFFSET = 3'h5;
  localparam logic [2:0] EOS_OFFSET      = 3'h7;
  // Control codes in bits 7-5 of the auxiliary mode port
  localparam logic [2:0] CODE_COMMAND = 3'h0;
  localparam logic [2:0] CODE_CFG_A   = 3'h4;
  localparam logic [2:0] CODE_CFG_B   = 3'h5;
  // Auxiliary commands under control code 000
  localparam logic [4:0] CMD_FINISH_HS = 5'h03;
  localparam logic [4:0] CMD_VALID     = 5'h0f;
  localparam logic [4:0] CMD_CLR_PPF   = 5'h05;
  localparam logic [4:0] CMD_SET_PPF   = 5'h0d;
  // Field positions of config word A
  localparam int HOLDOFF_ALL_POS = 0;
  localparam int HOLDOFF_END_POS = 1;
  localparam int END_ON_EOS_ENABLE_POS        = 2;
  localparam int BIN_POS         = 4;
  // Field positions of config word B
  localparam int CPT_EN_POS  = 0;
  localparam int SERIAL_POLL_END_BIT_POS   = 1;
  localparam int TRI_POS     = 2;
  localparam int INV_POS     = 3;
  localparam int ISS_POS     = 4;
  // Values after reset
  localparam logic [4:0] CFG_A_RESET = 5'h00;
  localparam logic [4:0] CFG_B_RESET = 5'h00;
  localparam logic [7:0] EOS_RESET   = 8'h00;
  // Source handshake settling times
  localparam int CLK_PERIOD_NS = 10;
  localparam int T1_FAST_NS    = 500;
  localparam int T1_SLOW_NS    = 2000;
  localparam logic [7:0] T1_FAST_CYCLES =
    8'((T1_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] T1_SLOW_CYCLES =
    8'((T1_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Buffer shape
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // Receive handshake modes, end bit first
  typedef enum logic [1:0] {
    GAHAC_NORMAL     = 2'b00,
    GAHAC_HOLD_ALL   = 2'b01,
    GAHAC_HOLD_END   = 2'b10,
    GAHAC_CONTINUOUS = 2'b11
  } gahac_mode_type;
endpackage : gahac_pkg

// >>> pkg/gahac_stream_if.sv
// Byte stream carrier between the control logic and its buffer
`timescale 1ns/1ps
interface gahac_stream_if #(parameter int WIDTH = 8);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport ctrl (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
  modport buffer (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
endinterface : gahac_stream_if
